// ===== rtl/ckos_regs.sv
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module ckos_regs
	import ckos_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [7:0] pix_red,
	input wire logic [7:0] pix_green,
	input wire logic [7:0] pix_blue,
	input wire logic [7:0] pix_overlay,
	output logic key_match,
	output logic key_invert_select,
	output logic blue_range_enable,
	output logic green_range_enable,
	output logic red_range_enable,
	output logic overlay_range_enable,
	output logic [7:0] border_red,
	output logic [7:0] border_green,
	output logic [7:0] border_blue
);
	ckos_state_s s_q;
	ckos_state_s s_d;

	logic take;
	logic mapped;
	logic [5:0] req_idx;
	logic border_we;
	logic [NUM_FIELDS-1:0] field_hit;
	logic [7:0] pix_value [NUM_FIELDS];

	assign pix_value[FIELD_RED] = pix_red;
	assign pix_value[FIELD_GREEN] = pix_green;
	assign pix_value[FIELD_BLUE] = pix_blue;
	assign pix_value[FIELD_OVERLAY] = pix_overlay;

	// address phase accepted: only word-aligned addresses in the low window map
	assign take = hsel && hready && (htrans == HTRANS_NONSEQ);
	assign req_idx = haddr[7:2];
	assign mapped = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);

	// border colour is written in the data phase like every other register
	assign border_we = (s_q.phase == CKOS_BUS_WRITE);

	ckos_border_store u_border (
		.hclk(hclk),
		.we(border_we),
		.idx(s_q.wr_idx),
		.wdata(hwdata[7:0]),
		.red(border_red),
		.green(border_green),
		.blue(border_blue)
	);

	genvar gf;
	generate
		for (gf = 0; gf < NUM_FIELDS; gf++) begin : g_field
			ckos_range_cmp u_cmp (
				.value(pix_value[gf]),
				.low(s_q.bnd[2*gf]),
				.high(s_q.bnd[2*gf+1]),
				.enable(s_q.ctrl[FIELD_EN_BIT[gf]]),
				.hit(field_hit[gf])
			);
		end
	endgenerate

	always_comb begin
		s_d = s_q;
		s_d.ready = 1'h1;
		s_d.resp = HRESP_OKAY;
		// data phase of a write: store the low byte (only bits 4:0 for the control register); upper lanes are ignored
		if (s_q.phase == CKOS_BUS_WRITE) begin
			if (s_q.wr_idx == IDX_KEY_SWITCH_CONTROL) begin
				s_d.ctrl = hwdata[CTRL_WIDTH-1:0];
			end else if (s_q.wr_idx[5:3] == IDX_KEY_RED_LOW[5:3]) begin
				s_d.bnd[s_q.wr_idx[2:0]] = hwdata[7:0];
				s_d.keys_written = 1'h1;
			end
		end
		s_d.phase = CKOS_BUS_IDLE;
		s_d.rdata = 8'h00;
		if (take && mapped && hwrite) begin
			s_d.phase = CKOS_BUS_WRITE;
			s_d.wr_idx = req_idx;
		end else if (take && mapped) begin
			// reads use the post-write view so a write just ahead is seen
			if (req_idx == IDX_KEY_SWITCH_CONTROL) begin
				s_d.rdata = {3'h0, s_d.ctrl};
			end else if (req_idx[5:3] == IDX_KEY_RED_LOW[5:3]) begin
				s_d.rdata = s_d.bnd[req_idx[2:0]];
			end else if (border_we && s_q.wr_idx == req_idx &&
				(req_idx == IDX_BORDER_RED || req_idx == IDX_BORDER_GREEN ||
				req_idx == IDX_BORDER_BLUE)) begin
				s_d.rdata = hwdata[7:0];
			end else if (req_idx == IDX_BORDER_RED) begin
				s_d.rdata = border_red;
			end else if (req_idx == IDX_BORDER_GREEN) begin
				s_d.rdata = border_green;
			end else if (req_idx == IDX_BORDER_BLUE) begin
				s_d.rdata = border_blue;
			end
		end
		// key result: all enabled fields in range, then optional inversion
		s_d.match = (&field_hit) ^ s_q.ctrl[CTRL_INVERT_BIT];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q.phase <= CKOS_BUS_IDLE;
			s_q.wr_idx <= 6'h00;
			s_q.rdata <= 8'h00;
			s_q.ready <= 1'h1;
			s_q.resp <= HRESP_OKAY;
			s_q.ctrl <= CTRL_RESET;
			for (int i = 0; i < NUM_FIELDS; i++) begin
				s_q.bnd[2*i] <= KEY_LOW_RESET;
				s_q.bnd[2*i+1] <= KEY_HIGH_RESET;
			end
			s_q.match <= 1'h0;
			s_q.keys_written <= 1'h0;
		end else begin
			s_q <= s_d;
		end
	end

	assign hrdata = {24'h000000, s_q.rdata};
	assign hreadyout = s_q.ready;
	assign hresp = s_q.resp;
	assign key_match = s_q.match;
	assign key_invert_select = s_q.ctrl[CTRL_INVERT_BIT];
	assign blue_range_enable = s_q.ctrl[CTRL_BLUE_BIT];
	assign green_range_enable = s_q.ctrl[CTRL_GREEN_BIT];
	assign red_range_enable = s_q.ctrl[CTRL_RED_BIT];
	assign overlay_range_enable = s_q.ctrl[CTRL_OVERLAY_BIT];

	// checks below watch only what this block drives

	sequence s_wr_addr(logic [5:0] idx);
		take && mapped && hwrite && req_idx == idx;
	endsequence

	sequence s_rd_addr(logic [5:0] idx);
		take && mapped && !hwrite && req_idx == idx;
	endsequence

	property p_always_ready;
		@(posedge hclk) disable iff (!hresetn)
		take |=> hreadyout && hresp == HRESP_OKAY;
	endproperty
	a_always_ready: assert property (p_always_ready)
		else $error("slave inserted a wait state or error");

	property p_ctrl_write;
		logic [7:0] d;
		@(posedge hclk) disable iff (!hresetn)
		s_wr_addr(IDX_KEY_SWITCH_CONTROL) ##1 (1'h1, d = hwdata[7:0])
			|=> key_invert_select == d[CTRL_INVERT_BIT] &&
			blue_range_enable == d[CTRL_BLUE_BIT] &&
			green_range_enable == d[CTRL_GREEN_BIT] &&
			red_range_enable == d[CTRL_RED_BIT] &&
			overlay_range_enable == d[CTRL_OVERLAY_BIT];
	endproperty
	a_ctrl_write: assert property (p_ctrl_write)
		else $error("control write did not land");

	property p_ctrl_readback;
		@(posedge hclk) disable iff (!hresetn)
		s_rd_addr(IDX_KEY_SWITCH_CONTROL) ##0 (s_q.phase == CKOS_BUS_IDLE)
			|=> hrdata == {27'h0000000, $past(s_q.ctrl)};
	endproperty
	a_ctrl_readback: assert property (p_ctrl_readback)
		else $error("control readback wrong or reserved bits set");

	property p_invert;
		@(posedge hclk) disable iff (!hresetn)
		##1 key_match == ($past(&field_hit) ^ $past(key_invert_select));
	endproperty
	a_invert: assert property (p_invert)
		else $error("key result not inverted as selected");

	property p_none_enabled;
		@(posedge hclk) disable iff (!hresetn)
		(s_q.ctrl[3:0] == 4'h0) |=> key_match == !$past(key_invert_select);
	endproperty
	a_none_enabled: assert property (p_none_enabled)
		else $error("disabled fields affected key result");

	property p_blue_out;
		@(posedge hclk) disable iff (!hresetn)
		(blue_range_enable && (pix_blue > s_q.bnd[2*FIELD_BLUE+1]))
			|=> key_match == $past(key_invert_select);
	endproperty
	a_blue_out: assert property (p_blue_out)
		else $error("blue above range still matched");

	property p_green_out;
		@(posedge hclk) disable iff (!hresetn)
		(green_range_enable && (pix_green < s_q.bnd[2*FIELD_GREEN]))
			|=> key_match == $past(key_invert_select);
	endproperty
	a_green_out: assert property (p_green_out)
		else $error("green below range still matched");

	property p_red_out;
		@(posedge hclk) disable iff (!hresetn)
		(red_range_enable && (pix_red > s_q.bnd[2*FIELD_RED+1]))
			|=> key_match == $past(key_invert_select);
	endproperty
	a_red_out: assert property (p_red_out)
		else $error("red above range still matched");

	property p_overlay_out;
		@(posedge hclk) disable iff (!hresetn)
		(overlay_range_enable && (pix_overlay < s_q.bnd[2*FIELD_OVERLAY]))
			|=> key_match == $past(key_invert_select);
	endproperty
	a_overlay_out: assert property (p_overlay_out)
		else $error("overlay below range still matched");

	property p_bounds_reset;
		@(posedge hclk) disable iff (!hresetn)
		!s_q.keys_written |-> s_q.bnd == {NUM_FIELDS{KEY_HIGH_RESET, KEY_LOW_RESET}};
	endproperty
	a_bounds_reset: assert property (p_bounds_reset)
		else $error("bound registers left their reset values");

	property p_high_reset;
		@(posedge hclk) disable iff (!hresetn)
		!s_q.keys_written |-> s_q.bnd[2*FIELD_OVERLAY+1] == KEY_HIGH_RESET;
	endproperty
	a_high_reset: assert property (p_high_reset)
		else $error("high bound not at reset value");

	property p_bound_write;
		logic [2:0] i;
		logic [7:0] d;
		@(posedge hclk) disable iff (!hresetn)
		(take && mapped && hwrite && req_idx[5:3] == IDX_KEY_RED_LOW[5:3],
			i = req_idx[2:0]) ##1 (1'h1, d = hwdata[7:0]) |=> s_q.bnd[i] == d;
	endproperty
	a_bound_write: assert property (p_bound_write)
		else $error("bound write lost");

	property p_bound_read;
		logic [7:0] v;
		@(posedge hclk) disable iff (!hresetn)
		(take && mapped && !hwrite && req_idx[5:3] == IDX_KEY_RED_LOW[5:3] &&
			s_q.phase == CKOS_BUS_IDLE, v = s_q.bnd[req_idx[2:0]])
			|=> hrdata[7:0] == v && hrdata[31:8] == 24'h000000;
	endproperty
	a_bound_read: assert property (p_bound_read)
		else $error("bound readback wrong");

	property p_border_write;
		logic [7:0] d;
		@(posedge hclk) disable iff (!hresetn)
		s_wr_addr(IDX_BORDER_GREEN) ##1 (1'h1, d = hwdata[7:0])
			|=> border_green == d;
	endproperty
	a_border_write: assert property (p_border_write)
		else $error("border green write lost");

	sequence s_border_store(logic [5:0] idx);
		border_we && s_q.wr_idx == idx;
	endsequence

	// border flops start unknown, so holding is checked only after a write
	property p_border_hold;
		@(posedge hclk) disable iff (!hresetn)
		s_border_store(IDX_BORDER_RED) ##1
			!(border_we && s_q.wr_idx == IDX_BORDER_RED) |=> $stable(border_red);
	endproperty
	a_border_hold: assert property (p_border_hold)
		else $error("border red changed without a write");

	property p_border_blue_hold;
		@(posedge hclk) disable iff (!hresetn)
		s_border_store(IDX_BORDER_BLUE) ##1
			!(border_we && s_q.wr_idx == IDX_BORDER_BLUE) |=> $stable(border_blue);
	endproperty
	a_border_blue_hold: assert property (p_border_blue_hold)
		else $error("border blue changed without a write");

	property p_red_in;
		@(posedge hclk) disable iff (!hresetn)
		(s_q.ctrl[3:0] == 4'h2 && pix_red >= s_q.bnd[2*FIELD_RED] &&
			pix_red <= s_q.bnd[2*FIELD_RED+1]) |=> key_match == !$past(key_invert_select);
	endproperty
	a_red_in: assert property (p_red_in)
		else $error("red inside range did not match");

	property p_upper_zero;
		@(posedge hclk) disable iff (!hresetn)
		take && !hwrite |=> hrdata[31:8] == 24'h000000;
	endproperty
	a_upper_zero: assert property (p_upper_zero)
		else $error("read data above bit 7 not zero");

	property p_ctrl_hold;
		@(posedge hclk) disable iff (!hresetn)
		!(s_q.phase == CKOS_BUS_WRITE && s_q.wr_idx == IDX_KEY_SWITCH_CONTROL)
			|=> $stable(key_invert_select) && $stable(blue_range_enable) &&
			$stable(green_range_enable) && $stable(red_range_enable) &&
			$stable(overlay_range_enable);
	endproperty
	a_ctrl_hold: assert property (p_ctrl_hold)
		else $error("control changed without a control write");

	property p_bound_hold;
		@(posedge hclk) disable iff (!hresetn)
		!(s_q.phase == CKOS_BUS_WRITE && s_q.wr_idx[5:3] == IDX_KEY_RED_LOW[5:3])
			|=> $stable(s_q.bnd);
	endproperty
	a_bound_hold: assert property (p_bound_hold)
		else $error("bound register changed without a write");

	property p_unmapped_read;
		@(posedge hclk) disable iff (!hresetn)
		take && !hwrite && !mapped |=> hrdata == 32'h00000000;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read)
		else $error("unmapped read returned data");

endmodule
`default_nettype wire

// ===== rtl/ckos_pkg.sv
package ckos_pkg;

	// register indices; the byte address on the bus is four times the index
	localparam logic [5:0] IDX_BORDER_RED = 6'h20;
	localparam logic [5:0] IDX_BORDER_GREEN = 6'h21;
	localparam logic [5:0] IDX_BORDER_BLUE = 6'h22;
	localparam logic [5:0] IDX_KEY_RED_LOW = 6'h30;
	localparam logic [5:0] IDX_KEY_RED_HIGH = 6'h31;
	localparam logic [5:0] IDX_KEY_GREEN_LOW = 6'h32;
	localparam logic [5:0] IDX_KEY_GREEN_HIGH = 6'h33;
	localparam logic [5:0] IDX_KEY_BLUE_LOW = 6'h34;
	localparam logic [5:0] IDX_KEY_BLUE_HIGH = 6'h35;
	localparam logic [5:0] IDX_KEY_OVERLAY_LOW = 6'h36;
	localparam logic [5:0] IDX_KEY_OVERLAY_HIGH = 6'h37;
	localparam logic [5:0] IDX_KEY_SWITCH_CONTROL = 6'h38;

	// key_switch_control fields
	localparam int CTRL_WIDTH = 5;
	localparam int CTRL_INVERT_BIT = 4;
	localparam int CTRL_BLUE_BIT = 3;
	localparam int CTRL_GREEN_BIT = 2;
	localparam int CTRL_RED_BIT = 1;
	localparam int CTRL_OVERLAY_BIT = 0;
	localparam logic [4:0] CTRL_RESET = 5'h10;

	// bound registers: field f has its low bound at slot 2f, high at 2f+1
	localparam int NUM_FIELDS = 4;
	localparam int NUM_BOUNDS = 8;
	localparam int FIELD_RED = 0;
	localparam int FIELD_GREEN = 1;
	localparam int FIELD_BLUE = 2;
	localparam int FIELD_OVERLAY = 3;
	localparam int FIELD_EN_BIT [NUM_FIELDS] = '{CTRL_RED_BIT, CTRL_GREEN_BIT,
		CTRL_BLUE_BIT, CTRL_OVERLAY_BIT};
	localparam logic [7:0] KEY_LOW_RESET = 8'h01;
	localparam logic [7:0] KEY_HIGH_RESET = 8'hFF;

	// AHB-Lite encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'h0;

	typedef enum logic {
		CKOS_BUS_IDLE,
		CKOS_BUS_WRITE
	} ckos_phase_e;

	typedef struct packed {
		ckos_phase_e phase;
		logic [5:0] wr_idx;
		logic [7:0] rdata;
		logic ready;
		logic resp;
		logic [4:0] ctrl;
		logic [NUM_BOUNDS-1:0][7:0] bnd;
		logic match;
		logic keys_written;
	} ckos_state_s;

	typedef struct packed {
		logic [7:0] red;
		logic [7:0] green;
		logic [7:0] blue;
	} ckos_border_s;

endpackage

// ===== rtl/ckos_range_cmp.sv
`timescale 1ns/1ns
`default_nettype none
module ckos_range_cmp (
	input wire logic [7:0] value,
	input wire logic [7:0] low,
	input wire logic [7:0] high,
	input wire logic enable,
	output logic hit
);
	// a disabled field never blocks the key; bounds are inclusive
	always_comb begin
		hit = !enable || ((value >= low) && (value <= high));
	end
endmodule
`default_nettype wire

// ===== rtl/ckos_border_store.sv
`timescale 1ns/1ns
`default_nettype none
module ckos_border_store
	import ckos_pkg::*;
(
	input wire logic hclk,
	input wire logic we,
	input wire logic [5:0] idx,
	input wire logic [7:0] wdata,
	output logic [7:0] red,
	output logic [7:0] green,
	output logic [7:0] blue
);
	ckos_border_s s_q;
	ckos_border_s s_d;

	// no reset on purpose: border colour holds garbage until software writes it
	always_comb begin
		s_d = s_q;
		if (we && idx == IDX_BORDER_RED) begin
			s_d.red = wdata;
		end else if (we && idx == IDX_BORDER_GREEN) begin
			s_d.green = wdata;
		end else if (we && idx == IDX_BORDER_BLUE) begin
			s_d.blue = wdata;
		end
	end

	always_ff @(posedge hclk) begin
		s_q <= s_d;
	end

	assign red = s_q.red;
	assign green = s_q.green;
	assign blue = s_q.blue;
endmodule
`default_nettype wire

// ===== tb/ckos_host.sv
`timescale 1ns/1ns
`default_nettype none
module ckos_host
	import ckos_pkg::*;
(
	input wire logic hclk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	int stalls;

	initial begin
		hsel = 1'h0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
		stalls = 0;
	end

	// bounded wait; a slave that never answers is counted, not hung on
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'h1 && n < 64);
		if (hready !== 1'h1) begin
			stalls++;
		end
	endtask

	// call right after a rising edge; returns at the edge that ends the data phase
	task automatic xfer(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
		output logic [31:0] rd);
		xfer_at(wr, {24'h0, idx, 2'h0}, wd, rd);
	endtask

	// any byte address, so misaligned and out-of-window ones can be offered too
	task automatic xfer_at(input logic wr, input logic [31:0] addr, input logic [7:0] wd,
		output logic [31:0] rd);
		hsel <= 1'h1;
		haddr <= addr;
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		wait_ready();
		hsel <= 1'h0;
		htrans <= 2'h0;
		// on reads the data lines toggle so stale data cannot pass for a store
		hwdata <= wr ? {24'h0, wd} : ~hwdata;
		wait_ready();
		rd = hrdata;
	endtask
endmodule
`default_nettype wire

// ===== tb/color_key_overscan_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module color_key_overscan_regs_tb
	import ckos_pkg::*;
;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, key_match;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [7:0] pix [4];
	logic [7:0] bred, bgreen, bblue, d;
	wire [4:0] ctrl_out;
	logic [7:0] shadow [64];
	logic [5:0] map [11] = '{6'h20, 6'h21, 6'h22, 6'h30, 6'h31, 6'h32, 6'h33, 6'h34, 6'h35,
		6'h36, 6'h37};
	logic [5:0] odd [3] = '{6'h23, 6'h39, 6'h38};
	logic [31:0] alias_addr [2] = '{32'h000001E0, 32'h000000E2};
	logic [4:0] c;
	int num_errors, num_checks;

	ckos_host host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

	ckos_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pix_red(pix[0]),
		.pix_green(pix[1]), .pix_blue(pix[2]), .pix_overlay(pix[3]), .key_match(key_match),
		.key_invert_select(ctrl_out[4]), .blue_range_enable(ctrl_out[3]),
		.green_range_enable(ctrl_out[2]), .red_range_enable(ctrl_out[1]),
		.overlay_range_enable(ctrl_out[0]), .border_red(bred), .border_green(bgreen),
		.border_blue(bblue));

	initial begin
		hclk = 1'h0;
		forever #25 hclk = ~hclk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up();
		num_errors += host.stalls;
		if (num_errors == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// no field enabled counts as in range, then the invert bit applies
	function automatic logic exp_match(input logic [4:0] cv);
		logic m;
		m = 1'h1;
		for (int f = 0; f < NUM_FIELDS; f++) begin
			if (cv[FIELD_EN_BIT[f]] && (pix[f] < shadow[48 + 2 * f] || pix[f] > shadow[49 + 2 * f])) begin
				m = 1'h0;
			end
		end
		return m ^ cv[CTRL_INVERT_BIT];
	endfunction

	// edge values of the window are where off-by-one compares show
	function automatic logic [7:0] near(input int f);
		case ($urandom % 5)
			0: return shadow[48 + 2 * f] - 8'h01;
			1: return shadow[48 + 2 * f];
			2: return shadow[49 + 2 * f];
			3: return shadow[49 + 2 * f] + 8'h01;
			default: return 8'($urandom);
		endcase
	endfunction

	initial begin
		#2500000;
		num_errors++;
		wrap_up();
	end

	initial begin
		hresetn = 1'h0;
		num_errors = 0;
		num_checks = 0;
		pix = '{8'h0, 8'h0, 8'h0, 8'h0};
		void'($urandom(51));
		foreach (shadow[i]) shadow[i] = 8'h00;
		for (int f = 0; f < NUM_FIELDS; f++) begin
			shadow[48 + 2 * f] = KEY_LOW_RESET;
			shadow[49 + 2 * f] = KEY_HIGH_RESET;
		end
		shadow[56] = 8'h10;
		repeat (2) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		@(negedge hclk);
		check({27'h0, ctrl_out}, 32'h10);
		check({31'h0, key_match}, {31'h0, exp_match(CTRL_RESET)});
		@(posedge hclk);
		for (int i = 48; i <= 56; i++) begin
			host.xfer(1'h0, i[5:0], 8'h00, rd);
			check(rd, {24'h0, shadow[i]});
			check({31'h0, hresp}, {31'h0, HRESP_OKAY});
		end
		for (int n = 0; n < 33; n++) begin
			d = (n < 11) ? {8{n[0]}} : 8'($urandom);
			if (n >= 22 && map[n % 11][5:4] == 2'h3) d = {map[n % 11][0], d[6:0]};
			host.xfer(1'h1, map[n % 11], d, rd);
			shadow[map[n % 11]] = d;
			host.xfer(1'h0, map[n % 11], 8'h00, rd);
			check(rd, {24'h0, d});
		end
		check({8'h0, bred, bgreen, bblue}, {8'h0, shadow[32], shadow[33], shadow[34]});
		foreach (odd[k]) begin
			host.xfer(1'h1, odd[k], 8'hFF, rd);
			if (odd[k] == 6'h38) shadow[56] = 8'h1F;
			host.xfer(1'h0, odd[k], 8'h00, rd);
			check(rd, {24'h0, shadow[odd[k]]});
		end
		// addresses outside the word map are ignored and read as zero
		foreach (alias_addr[k]) begin
			host.xfer_at(1'h1, alias_addr[k], 8'h00, rd);
			host.xfer_at(1'h0, alias_addr[k], 8'h00, rd);
			check(rd, 32'h0);
			host.xfer(1'h0, 6'h38, 8'h00, rd);
			check(rd, {24'h0, shadow[56]});
		end
		for (int n = 0; n < 40; n++) begin
			c = (n < 32) ? n[4:0] : 5'($urandom);
			host.xfer(1'h1, 6'h38, {3'h7, c}, rd);
			@(negedge hclk);
			check({27'h0, ctrl_out}, {27'h0, c});
			@(posedge hclk);
			repeat (4) begin
				for (int f = 0; f < NUM_FIELDS; f++) pix[f] <= near(f);
				@(posedge hclk);
				@(negedge hclk);
				check({31'h0, key_match}, {31'h0, exp_match(c)});
				@(posedge hclk);
			end
		end
		check({8'h0, bred, bgreen, bblue}, {8'h0, shadow[32], shadow[33], shadow[34]});
		wrap_up();
	end
endmodule
`default_nettype wire
